// File: rtl/pccu_pkg.sv
package pccu_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] MODE_CTRL_OFS = 8'hEB;
  localparam logic [7:0] CLK_CTRL_OFS = 8'hF0;
  localparam logic [7:0] CLK_STAT_OFS = 8'hF2;
  localparam logic [7:0] RST_FLAG_OFS = 8'hF3;
  localparam logic [7:0] PLL_SETUP_OFS = 8'hF6;

  // Reset values.
  localparam logic [7:0] MODE_CTRL_RST = 8'hE0;
  localparam logic [7:0] CLK_CTRL_RST = 8'h00;
  localparam logic [7:0] PLL_SETUP_RST = 8'h07;
  localparam logic CSU_RST = 1'h0;
  localparam logic XT_DIV16_RST = 1'h1;
  localparam logic [3:0] RST_FLAG_RST = 4'h1;

  // Mode control register fields.
  localparam int INPUT_HALVE_SELECT_BIT = 5;
  localparam int PRS_LSB = 2;
  // Clock control register fields.
  localparam int LOW_POWER_WAIT_ENABLE_BIT = 0;
  localparam int WFI_CKSEL_BIT = 1;
  localparam int CKAF_SEL_BIT = 2;
  localparam int SRESEN_BIT = 3;
  localparam int INT_SEL_BIT = 7;
  localparam logic [7:0] CLK_CTRL_MASK = 8'h8F;
  // Clock status register fields.
  localparam int CSU_BIT = 0;
  localparam int LOCK_BIT = 1;
  localparam int CKAF_ST_BIT = 2;
  localparam int XT_DIV16_BIT = 3;
  // Reset flag register fields.
  localparam int HW_FLAG_BIT = 0;
  localparam int SW_FLAG_BIT = 1;
  localparam int WDG_FLAG_BIT = 2;
  localparam int STOP_FLAG_BIT = 3;
  // PLL setup register fields.
  localparam int DX_LSB = 0;
  localparam int MX_LSB = 4;
  localparam logic [7:0] PLL_SETUP_MASK = 8'h37;

  localparam logic [2:0] DX_OFF = 3'h7;
  localparam logic [3:0] DIV16_RATIO = 4'hF;
  localparam int LOCK_REFS = 8;

  typedef enum {SRC_REF, SRC_REF16, SRC_AUX, SRC_AUX16, SRC_PLL}
    pccu_src_type;
  typedef enum {SW_RUN, SW_ALIGN} pccu_sw_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pccu_bus_type;

  typedef struct packed {
    logic cpu;
    logic sys;
    logic pll_raw;
    logic ref_clk;
  } pccu_tick_type;

  // Multiply select encoding to PLL factor.
  function automatic logic [3:0] pccu_mult(input logic [1:0] mx);
    case (mx)
      2'h0: pccu_mult = 4'hA;
      2'h1: pccu_mult = 4'h6;
      2'h2: pccu_mult = 4'hE;
      default: pccu_mult = 4'h8;
    endcase
  endfunction

endpackage

// File: rtl/pccu_tick_div.sv
`timescale 1ns/100ps
module pccu_tick_div #(
  parameter int W = 3
) (
  input wire logic clk, // Block clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic in_en, // Input rate tick.
  input wire logic [W-1:0] ratio, // Divides by ratio plus one.
  input wire logic clr, // Restarts the count.
  output logic out_en // Output rate tick.
);

  logic [W-1:0] cnt_q;

  // The last input tick of each group passes, so ratio zero keeps phase.
  assign out_en = in_en && (cnt_q >= ratio);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (clr) begin
      cnt_q <= '0;
    end else if (in_en) begin
      cnt_q <= (cnt_q >= ratio) ? '0 : cnt_q + W'(1);
    end
  end

endmodule

// File: rtl/pccu_top.sv
`timescale 1ns/100ps
// What this block does
// - Produces CPU core and peripheral system clocks.
// - Input halve select chooses reference as oscillator/2.
// - PLL multiplies reference by 6, 8, 10, 14.
// - Post divider divides PLL output by 1..7.
// - Divide select all ones switches PLL off.
// - Other divide select value turns PLL on, except in low power wait or stop.
// - PLL select bit moves system clock to PLL.
// - Lock logic sets settled flag when locked.
// - Low power selects reference divided by 16.
// - RC auxiliary clock, divided by 16 in low power wait.
// - System clock feeds peripherals and CPU prescaler.
// - CPU prescaler slows CPU by up to 8.
// - Undivided PLL output is a separate clock.
// - Reset manager flags hardware, software, watchdog resets.
// - External stop freezes all oscillators.
// - Mode control holds input halve and prescale.
// - Clock control holds low power and halt setting.
// - Clock status holds flags and source selects.
// - PLL setup holds multiply and divide fields.
// - Prescale zero is same clock; N divides N+1.
// - Plain wait stops CPU, system clock unchanged.
module pccu_top #(
  parameter int PER_W = 12
) (
  input wire logic MCLK, // Block clock, 100 MHz.
  input wire logic ARST_N, // Hardware reset, active low.
  input wire logic OSC_TICK, // Oscillator clock tick.
  input wire logic AUX_TICK, // RC auxiliary clock tick.
  input wire logic AUX_OK, // RC oscillator is running.
  input wire logic WFI_ACTIVE, // CPU sits in wait for interrupt.
  input wire logic STOP_REQ, // External stop mode level.
  input wire logic SW_RST_REQ, // Software reset event pulse.
  input wire logic WDG_RST_REQ, // Watchdog reset event pulse.
  input wire pccu_pkg::pccu_bus_type REG_BUS, // Register port request.
  output logic [7:0] REG_RDATA, // Read data, cycle after read.
  output pccu_pkg::pccu_tick_type CLK_TICKS, // Clock tick bundle.
  output logic PLL_LOCK, // PLL settled flag.
  output logic OSC_FREEZE, // Oscillators frozen.
  output logic RST_PULSE, // Internal reset request pulse.
  output logic HALT_RESET_EN // Halt interpretation setting.
);
  import pccu_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [7:0] mode_q;
  logic [7:0] clock_control_reg_q;
  logic [7:0] pll_q;
  logic [3:0] rflags_q;
  logic [3:0] rflags_d;
  logic csu_q;
  logic xt_div16_q;
  logic lock_q;
  logic ckaf_st;

  function automatic logic wr_hit(input pccu_bus_type b,
                                  input logic [7:0] ofs);
    wr_hit = b.wr && (b.addr == ofs);
  endfunction

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_q <= MODE_CTRL_RST;
    end else if (wr_hit(REG_BUS, MODE_CTRL_OFS)) begin
      mode_q <= REG_BUS.wdata;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      clock_control_reg_q <= CLK_CTRL_RST;
    end else if (wr_hit(REG_BUS, CLK_CTRL_OFS)) begin
      clock_control_reg_q <= REG_BUS.wdata & CLK_CTRL_MASK;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pll_q <= PLL_SETUP_RST;
    end else if (wr_hit(REG_BUS, PLL_SETUP_OFS)) begin
      pll_q <= REG_BUS.wdata & PLL_SETUP_MASK;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      csu_q <= CSU_RST;
      xt_div16_q <= XT_DIV16_RST;
    end else if (wr_hit(REG_BUS, CLK_STAT_OFS)) begin
      csu_q <= REG_BUS.wdata[CSU_BIT];
      xt_div16_q <= REG_BUS.wdata[XT_DIV16_BIT];
    end
  end

  // Reset cause flags survive internal resets; write one clears, and a
  // new event in the same cycle wins over the clear.
  always_comb begin
    rflags_d = rflags_q;
    if (wr_hit(REG_BUS, RST_FLAG_OFS)) begin
      rflags_d = rflags_q & ~REG_BUS.wdata[3:0];
    end
    if (SW_RST_REQ) begin
      rflags_d[SW_FLAG_BIT] = 1'h1;
    end
    if (WDG_RST_REQ) begin
      rflags_d[WDG_FLAG_BIT] = 1'h1;
    end
    if (STOP_REQ) begin
      rflags_d[STOP_FLAG_BIT] = 1'h1;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rflags_q <= RST_FLAG_RST;
      RST_PULSE <= 1'h0;
    end else begin
      rflags_q <= rflags_d;
      RST_PULSE <= SW_RST_REQ || WDG_RST_REQ;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_BUS.rd) begin
      case (REG_BUS.addr)
        MODE_CTRL_OFS: REG_RDATA <= mode_q;
        CLK_CTRL_OFS: REG_RDATA <= clock_control_reg_q;
        CLK_STAT_OFS: REG_RDATA <= {4'h0, xt_div16_q, ckaf_st, lock_q,
                                    csu_q};
        RST_FLAG_OFS: REG_RDATA <= {4'h0, rflags_q};
        PLL_SETUP_OFS: REG_RDATA <= pll_q;
        default: REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reference clocks.

  logic osc_en;
  logic aux_en;
  logic ref_en;
  logic ref16_en;
  logic aux16_en;
  logic lowpow;

  // Stop mode masks every oscillator tick at its source.
  assign osc_en = OSC_TICK && !STOP_REQ;
  assign aux_en = AUX_TICK && AUX_OK && !STOP_REQ;
  assign lowpow = WFI_ACTIVE && clock_control_reg_q[LOW_POWER_WAIT_ENABLE_BIT];

  pccu_tick_div #(.W(1)) u_ref_div (
    .clk(MCLK),
    .arst_n(ARST_N),
    .in_en(osc_en),
    .ratio(mode_q[INPUT_HALVE_SELECT_BIT]),
    .clr(1'h0),
    .out_en(ref_en)
  );

  pccu_tick_div #(.W(4)) u_ref16_div (
    .clk(MCLK),
    .arst_n(ARST_N),
    .in_en(ref_en),
    .ratio(DIV16_RATIO),
    .clr(1'h0),
    .out_en(ref16_en)
  );

  pccu_tick_div #(.W(4)) u_aux16_div (
    .clk(MCLK),
    .arst_n(ARST_N),
    .in_en(aux_en),
    .ratio(DIV16_RATIO),
    .clr(1'h0),
    .out_en(aux16_en)
  );

  //////////////////////////////////////////////////////////////////////////
  // PLL model: measures the reference period in MCLK cycles and spreads
  // mult ticks over it with an accumulator. Output rate must stay under
  // the MCLK rate.

  logic [2:0] dx;
  logic [3:0] mult;
  logic pll_on;
  logic pll_en;
  logic pll_div_en;
  logic [PER_W-1:0] per_cnt_q;
  logic [PER_W-1:0] per_q;
  logic [PER_W-1:0] per_new;
  logic [3:0] stable_q;
  logic [5:0] cfg_q;
  logic [PER_W:0] acc_q;
  logic [PER_W:0] acc_sum;

  assign dx = pll_q[DX_LSB +: 3];
  assign mult = pccu_mult(pll_q[MX_LSB +: 2]);
  // Low power wait and stop mode also force the PLL off.
  assign pll_on = (dx != DX_OFF) && !lowpow && !STOP_REQ;
  assign per_new = per_cnt_q + {{(PER_W-1){1'b0}}, 1'b1};
  assign acc_sum = acc_q + {{(PER_W-3){1'b0}}, mult};
  assign pll_en = pll_on && (per_q != '0)
                  && (acc_sum >= {1'b0, per_q});

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      per_cnt_q <= '0;
      per_q <= '0;
      stable_q <= 4'h0;
      cfg_q <= 6'h00;
    end else if (!pll_on) begin
      per_cnt_q <= '0;
      per_q <= '0;
      stable_q <= 4'h0;
      cfg_q <= pll_q[5:0];
    end else begin
      cfg_q <= pll_q[5:0];
      if (ref_en) begin
        per_cnt_q <= '0;
        per_q <= per_new;
      end else if (per_cnt_q != '1) begin
        per_cnt_q <= per_new;
      end
      // Lock needs a run of equal periods under one configuration.
      if (cfg_q != pll_q[5:0]) begin
        stable_q <= 4'h0;
      end else if (ref_en) begin
        if (per_new != per_q) begin
          stable_q <= 4'h0;
        end else if (stable_q < 4'(LOCK_REFS)) begin
          stable_q <= stable_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      acc_q <= '0;
    end else if (!pll_on) begin
      acc_q <= '0;
    end else begin
      acc_q <= pll_en ? acc_sum - {1'b0, per_q} : acc_sum;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lock_q <= 1'h0;
    end else begin
      lock_q <= pll_on && (cfg_q == pll_q[5:0])
                && (stable_q >= 4'(LOCK_REFS));
    end
  end

  pccu_tick_div #(.W(3)) u_post_div (
    .clk(MCLK),
    .arst_n(ARST_N),
    .in_en(pll_en),
    .ratio(dx),
    .clr(!pll_on),
    .out_en(pll_div_en)
  );

  //////////////////////////////////////////////////////////////////////////
  // System clock source switch.

  pccu_src_type cur_q;
  pccu_src_type want;
  pccu_sw_type sw_q;
  logic [4:0] tick_vec;
  logic cur_tick;
  logic cur_dead;
  logic sys_en;
  logic cpu_pre_en;

  assign tick_vec = {pll_div_en, aux16_en, aux_en, ref16_en, ref_en};
  assign cur_tick = tick_vec[cur_q];
  assign cur_dead = ((cur_q == SRC_PLL) && !pll_on)
                    || ((cur_q == SRC_AUX || cur_q == SRC_AUX16) && !AUX_OK);
  assign ckaf_st = (cur_q == SRC_AUX) || (cur_q == SRC_AUX16);

  always_comb begin
    if (lowpow) begin
      want = (clock_control_reg_q[WFI_CKSEL_BIT] && ckaf_st && AUX_OK)
             ? SRC_AUX16 : SRC_REF16;
    end else if (clock_control_reg_q[CKAF_SEL_BIT] && AUX_OK) begin
      want = SRC_AUX;
    end else if (!xt_div16_q) begin
      want = SRC_REF16;
    end else if (csu_q && pll_on) begin
      want = SRC_PLL;
    end else begin
      want = SRC_REF;
    end
  end

  // The old source finishes its period, then the first tick of the new
  // source is swallowed so the next period is whole.
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cur_q <= SRC_REF;
      sw_q <= SW_RUN;
    end else begin
      case (sw_q)
        SW_RUN: begin
          if ((want != cur_q) && (cur_tick || cur_dead)) begin
            cur_q <= want;
            sw_q <= SW_ALIGN;
          end
        end
        SW_ALIGN: begin
          // A source that dies before its first tick must not hang here.
          if (cur_tick || cur_dead) begin
            sw_q <= SW_RUN;
          end
        end
        default: sw_q <= SW_RUN;
      endcase
    end
  end

  assign sys_en = (sw_q == SW_RUN) && cur_tick;

  pccu_tick_div #(.W(3)) u_cpu_div (
    .clk(MCLK),
    .arst_n(ARST_N),
    .in_en(sys_en),
    .ratio(mode_q[PRS_LSB +: 3]),
    .clr(1'h0),
    .out_en(cpu_pre_en)
  );

  //////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign CLK_TICKS.sys = sys_en;
  assign CLK_TICKS.cpu = cpu_pre_en && !WFI_ACTIVE;
  assign CLK_TICKS.pll_raw = pll_en;
  assign CLK_TICKS.ref_clk = ref_en;
  assign PLL_LOCK = lock_q;
  assign OSC_FREEZE = STOP_REQ;
  assign HALT_RESET_EN = clock_control_reg_q[SRESEN_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!ARST_N);

  sequence s_switch_taken;
    (sw_q == SW_RUN) && (want != cur_q) && cur_tick;
  endsequence

  sequence s_first_new_tick;
    (sw_q == SW_ALIGN) && cur_tick;
  endsequence

  pll_off_a: assert property (
    (dx == DX_OFF) |-> !CLK_TICKS.pll_raw ##1 !PLL_LOCK)
    else $error("PLL ticks or lock while divide select is off");

  lock_drop_a: assert property (
    !pll_on |=> !PLL_LOCK)
    else $error("Lock flag held with PLL off");

  wfi_cpu_a: assert property (
    WFI_ACTIVE && !clock_control_reg_q[LOW_POWER_WAIT_ENABLE_BIT] && !$changed(want)
      && (sw_q == SW_RUN) |-> !CLK_TICKS.cpu && (want == cur_q
      || !$stable(clock_control_reg_q)))
    else $error("CPU ticks in wait or system source moved");

  prs_zero_a: assert property (
    (mode_q[PRS_LSB +: 3] == 3'h0) && $stable(mode_q) && !WFI_ACTIVE
      |-> CLK_TICKS.cpu == CLK_TICKS.sys)
    else $error("CPU tick differs from system tick at prescale zero");

  prs_gap_a: assert property (
    CLK_TICKS.sys && $stable(mode_q) && (mode_q[PRS_LSB +: 3] == 3'h7)
      && CLK_TICKS.cpu |=> !CLK_TICKS.cpu)
    else $error("CPU ticks back to back at prescale seven");

  switch_a: assert property (
    s_switch_taken |-> CLK_TICKS.sys
      ##1 (sw_q == SW_ALIGN) && !CLK_TICKS.sys)
    else $error("Old source tick lost on switch");

  swallow_a: assert property (
    s_first_new_tick |-> !CLK_TICKS.sys)
    else $error("First tick of new source not swallowed");

  align_a: assert property (
    s_first_new_tick |=> (sw_q == SW_RUN))
    else $error("Switch did not return to run");

  lowpow_a: assert property (
    lowpow && (sw_q == SW_RUN) && (cur_q == want)
      |-> (cur_q == SRC_REF16) || (cur_q == SRC_AUX16))
    else $error("Low power wait not on a divided source");

  pll_src_a: assert property (
    (sw_q == SW_RUN) && (cur_q == SRC_PLL) && CLK_TICKS.sys
      |-> pll_div_en && pll_on)
    else $error("System tick on PLL source without PLL");

  rst_flag_a: assert property (
    SW_RST_REQ |=> rflags_q[SW_FLAG_BIT] && RST_PULSE)
    else $error("Software reset not recorded");

  stop_a: assert property (
    STOP_REQ |-> !CLK_TICKS.sys && !CLK_TICKS.pll_raw && OSC_FREEZE
      ##1 rflags_q[STOP_FLAG_BIT])
    else $error("Clocks run during stop");

  ref_half_a: assert property (
    mode_q[INPUT_HALVE_SELECT_BIT] && $stable(mode_q) && ref_en |=> !ref_en)
    else $error("Reference not halved");

endmodule

// File: testbench/pccu_top_tb.sv
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
  end \
end
module pccu_top_tb;
  import pccu_pkg::*;
  localparam int OSC_P = 20;
  localparam int AUX_P = 12;
  localparam int REF_P = 40;
  logic MCLK = 1'b0;
  logic ARST_N = 1'b0;
  logic OSC_TICK = 1'b0;
  logic AUX_TICK = 1'b0;
  logic AUX_OK = 1'b0;
  logic WFI_ACTIVE = 1'b0;
  logic STOP_REQ = 1'b0;
  logic SW_RST_REQ = 1'b0;
  logic WDG_RST_REQ = 1'b0;
  pccu_bus_type bus = '0;
  logic [7:0] reg_rdata;
  pccu_tick_type clk_ticks;
  logic [3:0] tk;
  logic pll_lock;
  logic osc_freeze;
  logic rst_pulse;
  logic halt_reset_en;
  int errors = 0;
  int compares = 0;
  int osc_n = 0;
  int aux_n = 0;
  int c[4];
  int mult_tab[4] = '{10, 6, 14, 8};

  assign tk = clk_ticks;
  always #5 MCLK = ~MCLK;

  // Free-running oscillator and RC ticks; the RC one only while present.
  always @(posedge MCLK) begin
    osc_n <= (osc_n == OSC_P - 1) ? 0 : osc_n + 1;
    OSC_TICK <= (osc_n == OSC_P - 1);
    aux_n <= (aux_n == AUX_P - 1) ? 0 : aux_n + 1;
    AUX_TICK <= AUX_OK && (aux_n == AUX_P - 1);
  end

  pccu_top #(.PER_W(12)) dut (
    .MCLK(MCLK),
    .ARST_N(ARST_N),
    .OSC_TICK(OSC_TICK),
    .AUX_TICK(AUX_TICK),
    .AUX_OK(AUX_OK),
    .WFI_ACTIVE(WFI_ACTIVE),
    .STOP_REQ(STOP_REQ),
    .SW_RST_REQ(SW_RST_REQ),
    .WDG_RST_REQ(WDG_RST_REQ),
    .REG_BUS(bus),
    .REG_RDATA(reg_rdata),
    .CLK_TICKS(clk_ticks),
    .PLL_LOCK(pll_lock),
    .OSC_FREEZE(osc_freeze),
    .RST_PULSE(rst_pulse),
    .HALT_RESET_EN(halt_reset_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge MCLK);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge MCLK);
    bus.wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
                       input string nm);
    @(posedge MCLK);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge MCLK);
    bus.rd <= 1'b0;
    @(negedge MCLK);
    `CHK(nm, e, reg_rdata)
  endtask

  // Counts each tick over n cycles: c[3] cpu, c[2] sys, c[1] pll, c[0] ref.
  task automatic cnt(input int n);
    c = '{default: 0};
    repeat (n) begin
      @(negedge MCLK);
      for (int i = 0; i < 4; i++) c[i] += (tk[i] === 1'b1) ? 1 : 0;
    end
  endtask

  task automatic wait_lock();
    int k = 0;
    while (pll_lock !== 1'b1 && k < 3000) begin
      @(negedge MCLK);
      k++;
    end
    if (k >= 3000) begin
      errors++;
      $display("ERROR pll_lock expected 1 seen 0");
      test_done();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    `CHK("lock_reset", 1'b0, pll_lock)
    rdchk(MODE_CTRL_OFS, 8'hE0, "mode_reset");
    rdchk(CLK_CTRL_OFS, 8'h00, "ctrl_reset");
    rdchk(CLK_STAT_OFS, 8'h08, "stat_reset");
    rdchk(PLL_SETUP_OFS, 8'h07, "pll_reset");
    rdchk(8'h00, 8'h00, "unmapped");
    wr(MODE_CTRL_OFS, 8'hFF);
    rdchk(MODE_CTRL_OFS, 8'hFF, "mode_rw");
    wr(CLK_CTRL_OFS, 8'hFF);
    rdchk(CLK_CTRL_OFS, 8'h8F, "ctrl_rw");
    `CHK("halt_en", 1'b1, halt_reset_en)
    wr(CLK_STAT_OFS, 8'h0E);
    rdchk(CLK_STAT_OFS, 8'h08, "stat_ro");
    wr(PLL_SETUP_OFS, 8'hFF);
    rdchk(PLL_SETUP_OFS, 8'h37, "pll_rw");
    wr(PLL_SETUP_OFS, 8'h07);
    wr(CLK_CTRL_OFS, 8'h00);
    wr(MODE_CTRL_OFS, 8'hE0);
  endtask

  task automatic t_ref();
    cnt(REF_P * 10);
    `CHK("ref_halved", 10, c[0])
    `CHK("sys_ref", 10, c[2])
    `CHK("cpu_same", 10, c[3])
    wr(MODE_CTRL_OFS, 8'hC0);
    cnt(REF_P * 10);
    `CHK("ref_full", 20, c[0])
    wr(MODE_CTRL_OFS, 8'hE0);
    cnt(REF_P);
  endtask

  task automatic t_prescale();
    for (int n = 1; n < 8; n++) begin
      wr(MODE_CTRL_OFS, 8'hE0 | 8'(n << 2));
      cnt(REF_P * (n + 1));
      cnt(REF_P * (n + 1) * 2);
      `CHK("sys_full", 2 * (n + 1), c[2])
      `CHK("cpu_div", 2, c[3])
    end
    wr(MODE_CTRL_OFS, 8'hE0);
    @(posedge MCLK);
    WFI_ACTIVE <= 1'b1;
    cnt(REF_P * 10);
    `CHK("wfi_cpu", 0, c[3])
    `CHK("wfi_sys", 10, c[2])
    @(posedge MCLK);
    WFI_ACTIVE <= 1'b0;
  endtask

  task automatic t_div16();
    wr(CLK_STAT_OFS, 8'h00);
    cnt(REF_P * 16);
    cnt(REF_P * 32);
    `CHK("sys_ref16", 2, c[2])
    `CHK("ref_cont", 32, c[0])
    wr(CLK_STAT_OFS, 8'h08);
    wr(CLK_CTRL_OFS, 8'h01);
    WFI_ACTIVE <= 1'b1;
    cnt(REF_P * 20);
    cnt(REF_P * 32);
    `CHK("lowpow_ref16", 2, c[2])
    @(posedge MCLK);
    WFI_ACTIVE <= 1'b0;
    wr(CLK_CTRL_OFS, 8'h00);
    cnt(REF_P * 18);
  endtask

  task automatic t_aux();
    @(posedge MCLK);
    AUX_OK <= 1'b1;
    wr(CLK_CTRL_OFS, 8'h04);
    cnt(AUX_P * 6);
    rdchk(CLK_STAT_OFS, 8'h0C, "aux_status");
    cnt(AUX_P * 20);
    `CHK("sys_aux", 20, c[2])
    wr(CLK_CTRL_OFS, 8'h07);
    WFI_ACTIVE <= 1'b1;
    cnt(AUX_P * 16);
    cnt(AUX_P * 32);
    `CHK("sys_aux16", 2, c[2])
    `CHK("cpu_lowpow", 0, c[3])
    @(posedge MCLK);
    WFI_ACTIVE <= 1'b0;
    wr(CLK_CTRL_OFS, 8'h00);
    AUX_OK <= 1'b0;
    cnt(REF_P);
  endtask

  task automatic t_pll();
    for (int m = 0; m < 4; m++) begin
      wr(PLL_SETUP_OFS, {2'b00, m[1:0], 4'h0});
      wait_lock();
      rdchk(CLK_STAT_OFS, 8'h0A, "lock_flag");
      cnt(REF_P * 2);
      `CHK("pll_mult", 2 * mult_tab[m], c[1])
      wr(PLL_SETUP_OFS, 8'h07);
      cnt(4);
      `CHK("lock_off", 1'b0, pll_lock)
      cnt(REF_P * 2);
      `CHK("pll_off", 0, c[1])
    end
    // Multiply by 8, post divide by 3, then move the system clock over.
    wr(PLL_SETUP_OFS, 8'h32);
    wait_lock();
    wr(CLK_STAT_OFS, 8'h09);
    cnt(REF_P * 3);
    cnt(REF_P * 6);
    `CHK("sys_pll", 16, c[2])
    `CHK("raw_pll", 48, c[1])
    `CHK("cpu_pll", 16, c[3])
    wr(CLK_STAT_OFS, 8'h08);
    wr(PLL_SETUP_OFS, 8'h07);
  endtask

  task automatic t_rst();
    rdchk(RST_FLAG_OFS, 8'h01, "hw_flag");
    wr(RST_FLAG_OFS, 8'h01);
    @(posedge MCLK);
    SW_RST_REQ <= 1'b1;
    @(posedge MCLK);
    SW_RST_REQ <= 1'b0;
    @(negedge MCLK);
    `CHK("rst_pulse", 1'b1, rst_pulse)
    rdchk(RST_FLAG_OFS, 8'h02, "sw_flag");
    wr(RST_FLAG_OFS, 8'h02);
    WDG_RST_REQ <= 1'b1;
    @(posedge MCLK);
    WDG_RST_REQ <= 1'b0;
    rdchk(RST_FLAG_OFS, 8'h04, "wdg_flag");
    wr(RST_FLAG_OFS, 8'h04);
    rdchk(RST_FLAG_OFS, 8'h00, "flag_clr");
  endtask

  task automatic t_stop();
    @(posedge MCLK);
    STOP_REQ <= 1'b1;
    @(negedge MCLK);
    `CHK("freeze", 1'b1, osc_freeze)
    cnt(REF_P * 4);
    `CHK("stop_ref", 0, c[0])
    `CHK("stop_sys", 0, c[2])
    @(posedge MCLK);
    STOP_REQ <= 1'b0;
    cnt(REF_P);
    rdchk(RST_FLAG_OFS, 8'h08, "stop_flag");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge MCLK);
    ARST_N <= 1'b1;
    t_regs();
    t_ref();
    t_prescale();
    t_div16();
    t_aux();
    t_pll();
    t_rst();
    t_stop();
    test_done();
  end
endmodule
